/* File: spm_consts.svh */
// Constants of the multimode serial port: register map, fields, dividers.
// Assumes a 32-bit AHB-Lite word bus and one 250 MHz clock.
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH

// Word indexes, byte address is four times the index
`define SPM_IDX_CTRL 3'h0
`define SPM_IDX_BUF 3'h1
`define SPM_IDX_POWER_CONTROL_REG 3'h2
`define SPM_IDX_STATION_ADDRESS 3'h3
`define SPM_IDX_ADDRESS_MASK 3'h4
`define SPM_IDX_BAUD 3'h5

// Power control fields
`define SPM_POWER_CONTROL_REG_BAUD_DOUBLER 7
`define SPM_POWER_CONTROL_REG_FESEL 6

// Baud source fields
`define SPM_BAUD_TSEL 0
`define SPM_BAUD_RSEL 1

// Mode 0 bit time is twelve clocks, clock low for the first half
`define SPM_M0_LAST 4'h0b
`define SPM_M0_HALF 4'h6
`define SPM_M0_SAMPLE 4'h5
`define SPM_M0_BITS 4'h7

// Mode 2 oversampling tick: 16 ticks per bit, bit time 64 or 32 clocks
`define SPM_M2_SLOW_MAX 2'h3
`define SPM_M2_FAST_MAX 2'h1

// Oversampling positions and frame lengths
`define SPM_OVS_LAST 4'h0f
`define SPM_OVS_MID 4'h7
`define SPM_LAST_10 4'h9
`define SPM_LAST_11 4'h0a

`endif

/* File: spm_pkg.sv */
// Types of the multimode serial port.
// Assumes spm_consts.svh for all numeric constants.
package spm_pkg;

  typedef enum logic [1:0] {
    MODE_SHIFT,
    MODE_ASYNC8,
    MODE_FIXED9,
    MODE_TIMER9
  } spm_mode_e;

  typedef struct packed {
    logic sm0;
    logic sm1;
    logic sm2;
    logic ren;
    logic tb8;
    logic rb8;
    logic ti;
    logic ri;
    logic fe;
    logic frame_error_access_select;
    logic baud_doubler;
    logic tsel;
    logic rsel;
    logic [7:0] station_address;
    logic [7:0] address_mask;
    logic [7:0] rbuf;
    logic [1:0] div;
    logic tx_busy;
    logic m0_rx;
    logic [3:0] tx_tick;
    logic [3:0] tx_cnt;
    logic [10:0] tx_sh;
    logic rx_busy;
    logic [3:0] rx_tick;
    logic [3:0] rx_cnt;
    logic [8:0] rx_sh;
    logic s1;
    logic s2;
    logic s_prev;
    logic wr_pend;
    logic [2:0] wr_idx;
    logic [31:0] hrdata;
    logic hready;
    logic txd;
    logic rxd_o;
    logic rxd_oe;
    logic irq;
  } spm_state_s;

endpackage

/* File: spm_serial_port.sv */
// Multimode serial port with address filter, AHB-Lite register slave.
// Assumes timer overflow pulses on hclk and an unsynchronised rxd pin.
//
// Behaviour
// - Separate transmit and receive buffers share one address.
// - Mode 0 shifts eight bits LSB first with a clock at fosc/12.
// - Mode 1 frame is start, eight data, stop; stop lands in rx ninth bit.
// - Modes 2 and 3 add a ninth bit from tx ninth bit into rx ninth bit.
// - Mode 2 bit rate is fosc/64, or fosc/32 with baud doubler set.
// - Mode 3 equals mode 2 but takes its rate from a timer overflow.
// - Transmit and receive rates pick timer 1 or timer 2 independently.
// - Writing the serial buffer starts a transmission in every mode.
// - Mode 0 reception starts when receive done is clear and enabled.
// - Async reception starts on a falling start edge while enabled.
// - Two mode bits select modes 0 to 3.
// - Control bit 7 is frame error when access select is set, else mode.
// - Bad stop bit sets frame error; only software clears it.
// - Modes 2/3 with filter: receive done needs ninth bit and address.
// - Mode 1 with filter: receive done needs valid stop and address.
// - Mask bit one means address bit must match, zero is don't care.
// - Address filtering applies only in modes 1, 2 and 3.
// - Station address and mask are readable and writable.
// - Transmit done is set when a frame has been sent.
// - Receive done is set when a reception ends, subject to filter.
// - Receive enable permits reception; clear blocks it.
// - Interrupt is OR of both done flags, never auto-cleared.
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "spm_consts.svh"

module spm_serial_port (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Baud sources
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  // Serial pins
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out,
  // Interrupt request
  output logic serial_irq
);

  spm_pkg::spm_state_s r;
  spm_pkg::spm_state_s n;
  spm_pkg::spm_mode_e mode;
  logic sel;
  logic serial_buffer_wr;
  logic div_tick;
  logic tx_t;
  logic rx_t;
  logic [3:0] last;
  logic [7:0] rx_data;
  logic rx_nin;
  logic match;
  logic bcast;
  logic accept;

  always_comb begin
    n = r;
    mode = spm_pkg::spm_mode_e'({r.sm0, r.sm1});
    sel = hsel && htrans[1] && hready && (haddr[31:5] == 27'h000_0000);
    serial_buffer_wr = 1'b0;
    rx_data = 8'h00;
    rx_nin = 1'b0;
    match = 1'b0;
    bcast = 1'b0;
    accept = 1'b0;
    last = (mode == spm_pkg::MODE_ASYNC8) ? `SPM_LAST_10 : `SPM_LAST_11;
    // Pin synchroniser
    n.s1 = rxd_in;
    n.s2 = r.s1;
    n.s_prev = r.s2;
    // Fixed oversampling tick for mode 2
    div_tick = (r.div == 2'h0);
    if (r.div == (r.baud_doubler ? `SPM_M2_FAST_MAX : `SPM_M2_SLOW_MAX)) begin
      n.div = 2'h0;
    end else begin
      n.div = r.div + 2'h1;
    end
    tx_t = (mode == spm_pkg::MODE_FIXED9) ? div_tick : (r.tsel ? timer2_ovf : timer1_ovf);
    rx_t = (mode == spm_pkg::MODE_FIXED9) ? div_tick : (r.rsel ? timer2_ovf : timer1_ovf);
    // Register writes in the data phase
    if (r.wr_pend) begin
      unique case (r.wr_idx)
        `SPM_IDX_CTRL: begin
          if (r.frame_error_access_select) begin
            n.fe = hwdata[7];
          end else begin
            n.sm0 = hwdata[7];
          end
          n.sm1 = hwdata[6];
          n.sm2 = hwdata[5];
          n.ren = hwdata[4];
          n.tb8 = hwdata[3];
          n.rb8 = hwdata[2];
          n.ti = hwdata[1];
          n.ri = hwdata[0];
        end
        `SPM_IDX_BUF: serial_buffer_wr = 1'b1;
        `SPM_IDX_POWER_CONTROL_REG: begin
          n.baud_doubler = hwdata[`SPM_POWER_CONTROL_REG_BAUD_DOUBLER];
          n.frame_error_access_select = hwdata[`SPM_POWER_CONTROL_REG_FESEL];
        end
        `SPM_IDX_STATION_ADDRESS: n.station_address = hwdata[7:0];
        `SPM_IDX_ADDRESS_MASK: n.address_mask = hwdata[7:0];
        `SPM_IDX_BAUD: begin
          n.tsel = hwdata[`SPM_BAUD_TSEL];
          n.rsel = hwdata[`SPM_BAUD_RSEL];
        end
        default: ;
      endcase
    end
    // Transmit engine, also runs mode 0 reception
    if (serial_buffer_wr) begin
      n.tx_busy = 1'b1;
      n.m0_rx = 1'b0;
      n.tx_tick = 4'h0;
      n.tx_cnt = 4'h0;
      if (mode == spm_pkg::MODE_SHIFT) begin
        n.tx_sh = {3'h7, hwdata[7:0]};
      end else if (mode == spm_pkg::MODE_ASYNC8) begin
        n.tx_sh = {2'h3, hwdata[7:0], 1'b0};
      end else begin
        n.tx_sh = {1'b1, r.tb8, hwdata[7:0], 1'b0};
      end
    end else if (r.tx_busy) begin
      if (mode == spm_pkg::MODE_SHIFT) begin
        n.tx_tick = (r.tx_tick == `SPM_M0_LAST) ? 4'h0 : r.tx_tick + 4'h1;
        if (r.m0_rx && r.tx_tick == `SPM_M0_SAMPLE) begin
          n.tx_sh[7:0] = {r.s2, r.tx_sh[7:1]};
        end
        if (r.tx_tick == `SPM_M0_LAST) begin
          n.tx_cnt = r.tx_cnt + 4'h1;
          if (!r.m0_rx) begin
            n.tx_sh = {1'b1, r.tx_sh[10:1]};
          end
          if (r.tx_cnt == `SPM_M0_BITS) begin
            n.tx_busy = 1'b0;
            if (r.m0_rx) begin
              n.rbuf = r.tx_sh[7:0];
              n.ri = 1'b1;
            end else begin
              n.ti = 1'b1;
            end
          end
        end
      end else if (tx_t) begin
        n.tx_tick = r.tx_tick + 4'h1;
        if (r.tx_tick == `SPM_OVS_LAST) begin
          n.tx_sh = {1'b1, r.tx_sh[10:1]};
          n.tx_cnt = r.tx_cnt + 4'h1;
          if (r.tx_cnt == last) begin
            n.tx_busy = 1'b0;
            n.ti = 1'b1;
          end
        end
      end
    end else if (mode == spm_pkg::MODE_SHIFT && r.ren && !r.ri) begin
      n.tx_busy = 1'b1;
      n.m0_rx = 1'b1;
      n.tx_tick = 4'h0;
      n.tx_cnt = 4'h0;
    end
    // Asynchronous receive engine
    if (mode == spm_pkg::MODE_SHIFT || !r.ren) begin
      n.rx_busy = 1'b0;
    end else if (!r.rx_busy) begin
      if (r.s_prev && !r.s2) begin
        n.rx_busy = 1'b1;
        n.rx_tick = 4'h0;
        n.rx_cnt = 4'h0;
      end
    end else if (rx_t) begin
      n.rx_tick = r.rx_tick + 4'h1;
      if (r.rx_tick == `SPM_OVS_MID) begin
        n.rx_cnt = r.rx_cnt + 4'h1;
        if (r.rx_cnt == 4'h0) begin
          n.rx_busy = !r.s2;
        end else if (r.rx_cnt != last) begin
          n.rx_sh = {r.s2, r.rx_sh[8:1]};
        end else begin
          n.rx_busy = 1'b0;
          if (mode == spm_pkg::MODE_ASYNC8) begin
            rx_data = r.rx_sh[8:1];
            rx_nin = r.s2;
          end else begin
            rx_data = r.rx_sh[7:0];
            rx_nin = r.rx_sh[8];
          end
          match = ((rx_data ^ r.station_address) & r.address_mask) == 8'h00;
          bcast = &(rx_data | ~(r.station_address | r.address_mask));
          if (mode == spm_pkg::MODE_ASYNC8) begin
            accept = !r.sm2 || (r.s2 && (match || bcast));
          end else begin
            accept = !r.sm2 || (rx_nin && (match || bcast));
          end
          if (!r.s2) begin
            n.fe = 1'b1;
          end
          if (accept) begin
            n.rbuf = rx_data;
            n.rb8 = rx_nin;
            n.ri = 1'b1;
          end
        end
      end
    end
    // Bus address phase and read data
    n.wr_pend = sel && hwrite;
    n.wr_idx = haddr[4:2];
    n.hready = 1'b1;
    n.hrdata = 32'h0000_0000;
    if (sel && !hwrite) begin
      unique case (haddr[4:2])
        `SPM_IDX_CTRL: n.hrdata[7:0] = {(n.frame_error_access_select ? n.fe : n.sm0), n.sm1, n.sm2, n.ren,
                                        n.tb8, n.rb8, n.ti, n.ri};
        `SPM_IDX_BUF: n.hrdata[7:0] = n.rbuf;
        `SPM_IDX_POWER_CONTROL_REG: begin
          n.hrdata[`SPM_POWER_CONTROL_REG_BAUD_DOUBLER] = n.baud_doubler;
          n.hrdata[`SPM_POWER_CONTROL_REG_FESEL] = n.frame_error_access_select;
        end
        `SPM_IDX_STATION_ADDRESS: n.hrdata[7:0] = n.station_address;
        `SPM_IDX_ADDRESS_MASK: n.hrdata[7:0] = n.address_mask;
        `SPM_IDX_BAUD: n.hrdata[1:0] = {n.rsel, n.tsel};
        default: ;
      endcase
    end
    // Pin and interrupt outputs
    if (mode == spm_pkg::MODE_SHIFT && n.tx_busy) begin
      n.txd = (n.tx_tick >= `SPM_M0_HALF);
    end else begin
      n.txd = !n.tx_busy || n.tx_sh[0];
    end
    n.rxd_o = n.tx_sh[0];
    n.rxd_oe = (mode == spm_pkg::MODE_SHIFT) && n.tx_busy && !n.m0_rx;
    n.irq = n.ti || n.ri;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.s1 <= 1'b1;
      r.s2 <= 1'b1;
      r.s_prev <= 1'b1;
      r.hready <= 1'b1;
      r.txd <= 1'b1;
      r.rxd_o <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign hrdata = r.hrdata;
  assign hreadyout = r.hready;
  assign hresp = 1'b0;
  assign txd_out = r.txd;
  assign rxd_out = r.rxd_o;
  assign rxd_oe = r.rxd_oe;
  assign serial_irq = r.irq;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence m0_clock_low_high;
    !txd_out [*6] ##1 txd_out [*6];
  endsequence

  sequence async_start_bit;
    txd_out ##1 !txd_out;
  endsequence

  irq_or_flags_a: assert property (serial_irq == (r.ti || r.ri))
    else $error("serial_irq differs from the done flags");

  m0_shift_clock_a: assert property (serial_buffer_wr && mode == spm_pkg::MODE_SHIFT && !r.tx_busy
    |=> m0_clock_low_high)
    else $error("mode 0 shift clock is not six low then six high");

  tx_start_bit_a: assert property (serial_buffer_wr && mode != spm_pkg::MODE_SHIFT && !r.tx_busy
    |-> async_start_bit)
    else $error("transmit start bit did not follow buffer write");

  m2_tick_slow_a: assert property (mode == spm_pkg::MODE_FIXED9 && !r.baud_doubler && $stable(r.baud_doubler)
    && div_tick |=> !div_tick [*3] ##1 div_tick)
    else $error("mode 2 oversample tick not every four clocks");

  m2_tick_fast_a: assert property (mode == spm_pkg::MODE_FIXED9 && r.baud_doubler && $stable(r.baud_doubler)
    && div_tick |=> !div_tick ##1 div_tick)
    else $error("mode 2 oversample tick not every two clocks");

  fe_sticky_a: assert property (r.fe && !(r.wr_pend && r.wr_idx == `SPM_IDX_CTRL)
    |=> r.fe)
    else $error("frame error cleared without software write");

  ren_blocks_rx_a: assert property (!r.ren |=> !r.rx_busy)
    else $error("receiver active while reception disabled");

  filt_ninth_a: assert property ($rose(r.ri) && $past(r.sm2) && !$past(r.wr_pend)
    && $past(mode) != spm_pkg::MODE_SHIFT && $past(mode) != spm_pkg::MODE_ASYNC8
    |-> r.rb8)
    else $error("filtered receive done without ninth bit set");

  tx_done_flag_a: assert property ($fell(r.tx_busy) && !$past(r.m0_rx) |-> r.ti)
    else $error("transmit done flag not set after frame");

  false_start_a: assert property (r.rx_busy && r.rx_cnt == 4'h0 && r.rx_tick == `SPM_OVS_MID
    && rx_t && r.s2 && r.ren && mode != spm_pkg::MODE_SHIFT |=> !r.rx_busy)
    else $error("false start bit was not rejected");

endmodule // spm_serial_port

/* File: spm_peer.sv */
// Remote serial peer: drives frames into the receive pin, captures sent frames.
// Assumes the bench clock and an idle-high serial line.
`timescale 1ns/1ps

module spm_peer (
  // Clock
  input wire logic hclk,
  // Line
  input wire logic txd,
  input wire logic pin,
  output logic prx
);
  initial prx = 1'b1;

  // Start bit in f[0], then data LSB first, ninth bit, stop bit
  task automatic send(input logic [10:0] f, input int n, input int len);
    for (int i = 0; i < n; i++) begin
      @(posedge hclk) prx <= f[i];
      repeat (len - 1) @(posedge hclk);
    end
    @(posedge hclk) prx <= 1'b1;
  endtask

  // Async capture, sampled at each bit midpoint
  task automatic grab(output logic [10:0] f, input int n, input int len);
    f = '0;
    @(negedge txd);
    repeat (len / 2) @(posedge hclk);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (len) @(posedge hclk);
    end
  endtask

  // Shift mode capture on each rising shift clock; period in ns
  task automatic grab0(output logic [7:0] d, output time per);
    time t;
    t = $time;
    for (int i = 0; i < 8; i++) begin
      @(posedge txd) d[i] = pin;
      per = $time - t;
      t = $time;
    end
  endtask

  // Shift mode receive: next bit on each falling shift clock
  task automatic put0(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd) prx <= d[i];
      @(posedge txd);
    end
    prx <= 1'b1;
  endtask
endmodule // spm_peer

/* File: spm_serial_port_tb.sv */
// Bench of the multimode serial port: AHB-Lite register calls and peer frames.
// Assumes the design answers with zero wait states and a 4 ns clock.
`timescale 1ns/1ps
`include "spm_consts.svh"

module spm_serial_port_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic t1 = 1'b0;
  logic t2 = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0] htrans = '0;
  logic [2:0] tc = '0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, rxd_out, rxd_oe, txd_out, irq, prx, pin;
  logic [10:0] f;
  logic [7:0] d;
  time per;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [10:0] fr [3] = '{11'h702, 11'h302, 11'h702};
  logic [7:0] fx [3] = '{8'h15, 8'h95, 8'h95};
  logic [7:0] gb [5] = '{8'h82, 8'hc2, 8'hc0, 8'hfd, 8'hc2};
  logic gn [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  logic gr [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [7:0] gc [5] = '{8'h30, 8'h30, 8'h30, 8'h30, 8'h20};

  assign pin = rxd_oe ? rxd_out : prx;

  spm_serial_port u_spm_serial_port (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer1_ovf(t1),
    .timer2_ovf(t2), .rxd_in(pin), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .txd_out(txd_out), .serial_irq(irq)
  );

  spm_peer u_spm_peer (.hclk(hclk), .txd(txd_out), .pin(pin), .prx(prx));

  initial begin
    forever #2 hclk = ~hclk;
  end

  // Timer overflows: timer 1 every 2 clocks, timer 2 every 4 clocks
  always @(posedge hclk) begin
    tc <= tc + 3'h1;
    t1 <= tc[0];
    t2 <= &tc[1:0];
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [2:0] i, input logic w, input logic [7:0] v,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {27'h0, i, 2'h0};
    hwrite <= w;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, v};
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    q = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] i, input logic [7:0] v);
    logic [31:0] q;
    xfer(i, 1'b1, v, q);
  endtask

  task automatic rd(input logic [2:0] i, input logic [31:0] e, input logic [31:0] m = '1);
    logic [31:0] q;
    xfer(i, 1'b0, 8'h00, q);
    chk(q & m, e);
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`SPM_IDX_CTRL, 32'h0000_0000);
    rd(3'h6, 32'h0000_0000);
    // Shift mode transmit
    wr(`SPM_IDX_BUF, 8'h5a);
    u_spm_peer.grab0(d, per);
    chk({24'h0, d}, 32'h0000_005a);
    chk(per[31:0], 32'h0000_0030);
    repeat (12) @(posedge hclk);
    rd(`SPM_IDX_CTRL, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`SPM_IDX_CTRL, 8'h00);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0000_0000);
    // Mode 3 transmit on timer 2, mode 1 receive on timer 1
    wr(`SPM_IDX_BAUD, 8'h01);
    wr(`SPM_IDX_CTRL, 8'hc8);
    fork
      u_spm_peer.grab(f, 11, 64);
      wr(`SPM_IDX_BUF, 8'ha5);
    join
    chk({21'h0, f}, 32'h0000_074a);
    rd(`SPM_IDX_CTRL, 32'h0000_00ca);
    wr(`SPM_IDX_CTRL, 8'h50);
    u_spm_peer.send(11'h678, 10, 32);
    repeat (4) @(posedge hclk);
    rd(`SPM_IDX_BUF, 32'h0000_003c);
    rd(`SPM_IDX_CTRL, 32'h0000_0055);
    // Mode 2 receive with doubler, frame error view
    wr(`SPM_IDX_POWER_CONTROL_REG, 8'h80);
    wr(`SPM_IDX_CTRL, 8'h90);
    wr(`SPM_IDX_POWER_CONTROL_REG, 8'hc0);
    for (int i = 0; i < 3; i++) begin
      u_spm_peer.send(fr[i], 11, 32);
      repeat (4) @(posedge hclk);
      rd(`SPM_IDX_CTRL, {24'h0, fx[i]});
    end
    rd(`SPM_IDX_BUF, 32'h0000_0081);
    // Address filter
    wr(`SPM_IDX_STATION_ADDRESS, 8'hc0);
    wr(`SPM_IDX_ADDRESS_MASK, 8'hfd);
    rd(`SPM_IDX_STATION_ADDRESS, 32'h0000_00c0);
    rd(`SPM_IDX_ADDRESS_MASK, 32'h0000_00fd);
    for (int i = 0; i < 5; i++) begin
      wr(`SPM_IDX_CTRL, gc[i]);
      u_spm_peer.send({1'b1, gn[i], gb[i], 1'b0}, 11, 32);
      repeat (4) @(posedge hclk);
      rd(`SPM_IDX_CTRL, {31'h0, gr[i]}, 32'h0000_0081);
    end
    rd(`SPM_IDX_BUF, 32'h0000_00fd);
    // Shift mode receive ignores the address filter
    wr(`SPM_IDX_POWER_CONTROL_REG, 8'h00);
    fork
      u_spm_peer.put0(8'h96);
      wr(`SPM_IDX_CTRL, 8'h30);
    join
    repeat (8) @(posedge hclk);
    rd(`SPM_IDX_BUF, 32'h0000_0096);
    rd(`SPM_IDX_CTRL, 32'h0000_0031);
    summarize();
  end
endmodule // spm_serial_port_tb
